// File: tfm_echo_model.sv
// Purpose: Front-end stand-in answering a trigger with start and stop.
// Assumes: Pulses are one clk wide, launched on the rising edge.
// Notes:   Stop rises gap_in cycles after start.
`timescale 1ns/1ps
module tfm_echo_model
  import tfm_pkg::*;
#(
  parameter int LAT = 8
)
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Pins facing the sequencer
  input  wire logic       trigger_in,
  input  wire logic [9:0] gap_in,
  output logic            start_out,
  output logic            stop_out
);
  logic        trig_q;
  logic        run;
  logic [10:0] cnt;

  // Trigger rise arms one transmit; short pulses show only their edges
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {trig_q, run, cnt, start_out, stop_out} <= '0;
    end else begin
      trig_q    <= trigger_in;
      start_out <= 1'b0;
      stop_out  <= 1'b0;
      if (trigger_in && !trig_q) begin
        run <= 1'b1;
        cnt <= 11'h000;
      end else if (run) begin
        cnt <= cnt + 11'h001;
        start_out <= (cnt == 11'(LAT));
        if (cnt == 11'(LAT) + {1'b0, gap_in}) begin
          stop_out <= 1'b1;
          run      <= 1'b0;
        end
      end
    end
  end
endmodule : tfm_echo_model

// File: tfm_par_reg.sv
// Purpose: Read-only result word with parity over its 23 value bits.
// Assumes: Load is a one-cycle strobe from the sequencer.
// Notes:   Parity is even: the XOR of all 24 bits is zero.
`timescale 1ns/1ps
`include "tfm_params.svh"

module tfm_par_reg
  import tfm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Load side
  input  wire logic        load_in,
  input  wire logic [22:0] value_in,
  // Stored word
  output tfm_word_t        word_out
);

  tfm_preg_st_t st;
  tfm_preg_st_t next_st;

  // ----------------------------------------
  // Load with fresh parity
  // ----------------------------------------
  always_comb begin
    next_st = st;
    if (load_in) begin
      next_st.word.value  = value_in;
      next_st.word.parity = ^value_in;
    end
  end

  // Cleared word after reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= `TFM_RESULT_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign word_out = st.word;

endmodule : tfm_par_reg

// File: tfm_params.svh
// Purpose: Constants for the time-of-flight measurement sequencer.
// Assumes: Register addresses are 6-bit serial-port addresses.
// Notes:   Offsets, field positions, reset values and timing counts.
`ifndef TFM_PARAMS_SVH
`define TFM_PARAMS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define TFM_ADDR_CONFIG      6'h00
`define TFM_ADDR_STATUS      6'h01
`define TFM_ADDR_MEAS_RESULT 6'h10
`define TFM_ADDR_FIRST_CAL   6'h1B
`define TFM_ADDR_SECOND_CAL  6'h1C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TFM_CFG_START_BIT    0
`define TFM_STS_BUSY_BIT     0
`define TFM_STS_DONE_BIT     1
`define TFM_STS_OVF_BIT      2
`define TFM_PARITY_BIT       23
`define TFM_VALUE_MSB        22

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TFM_RESULT_RESET     24'h000000

// ----------------------------------------
// Serial frame layout
// ----------------------------------------
`define TFM_CMD_BITS         5'h08
`define TFM_WR_LAST_BIT      5'h0F
`define TFM_CMD_WRITE_BIT    6

// ----------------------------------------
// Timing
// ----------------------------------------
`define TFM_CLK_PERIOD_PS    5000
`define TFM_TRIG_PULSE_NS    20
`define TFM_TRIG_CYCLES      ((`TFM_TRIG_PULSE_NS * 1000 + `TFM_CLK_PERIOD_PS - 1) / `TFM_CLK_PERIOD_PS)
`define TFM_CAL2_PERIODS     10

`endif

// File: tfm_pkg.sv
// Purpose: Types shared by the measurement sequencer files.
// Assumes: 23-bit results with one parity bit on top.
// Notes:   State of tfm_par_reg and tfm_seq_top is one packed struct each.
package tfm_pkg;

  // ----------------------------------------
  // Result word and sequencer states
  // ----------------------------------------
  typedef struct packed {
    logic        parity;
    logic [22:0] value;
  } tfm_word_t;

  typedef enum logic [2:0] {
    TFM_IDLE,
    TFM_TRIGGER,
    TFM_WAIT_START,
    TFM_COUNT,
    TFM_CAL_SYNC,
    TFM_CAL_FIRST,
    TFM_CAL_SECOND
  } tfm_state_t;

  // ----------------------------------------
  // Whole-module state records
  // ----------------------------------------
  typedef struct packed {
    tfm_word_t word;
  } tfm_preg_st_t;

  typedef struct packed {
    tfm_state_t  state;
    logic [7:0]  trig_cnt;
    logic [22:0] meas_cnt;
    logic [22:0] cal_cnt;
    logic [7:0]  ref_periods;
    logic        start_prev;
    logic        stop_prev;
    logic        ref_prev;
    logic        sclk_prev;
    logic [4:0]  bit_cnt;
    logic [7:0]  rx;
    logic [5:0]  addr;
    logic        wr;
    logic [23:0] tx;
    logic        done;
    logic        ovf;
    logic        trigger;
  } tfm_main_st_t;

endpackage : tfm_pkg

// File: tfm_seq_chk.sv
// Purpose: Port-level checks for the measurement sequencer.
// Assumes: All watched pins are sampled on clk_in.
// Notes:   Bound to every tfm_seq_top instance.
`timescale 1ns/1ps
module tfm_seq_chk
  import tfm_pkg::*;
#(
  parameter int TRIG_CYCLES = 4
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Watched pins
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdo_out,
  input wire logic trigger_out,
  input wire logic start_in,
  input wire logic stop_in
);
  logic [7:0] hi_cnt;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // ----
  // Helper
  // ----
  // Counts trigger cycles, since a repetition cannot take a parameter
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hi_cnt <= 8'h00;
    end else begin
      hi_cnt <= trigger_out ? hi_cnt + 8'h01 : 8'h00;
    end
  end

  // ----
  // Assertions
  // ----
  a_trig_width: assert property ($fell(trigger_out) |-> hi_cnt == TRIG_CYCLES)
    else $error("trigger pulse width wrong");
  a_trig_cause: assert property ($rose(trigger_out) |-> !$past(cs_n_in, 2))
    else $error("trigger without a command frame");
  a_trig_once: assert property ($fell(trigger_out) |-> !trigger_out [*8])
    else $error("trigger repeated too soon");
  a_reset_quiet: assert property ($rose(rst_n_in) |-> !trigger_out && !sdo_out)
    else $error("outputs not clear after reset");
  a_sdo_on_fall: assert property ($changed(sdo_out) && !$past(cs_n_in) |-> !$past(sclk_in))
    else $error("serial data moved while clock high");
  a_sdo_desel_quiet: assert property (cs_n_in && $past(cs_n_in) |-> $stable(sdo_out))
    else $error("serial data moved while deselected");

  // Main scenarios reached
  c_start: cover property ($rose(start_in));
  c_stop: cover property ($rose(stop_in));
  c_trig: cover property ($fell(trigger_out));
endmodule : tfm_seq_chk

bind tfm_seq_top tfm_seq_chk #(.TRIG_CYCLES(TRIG_CYCLES)) tfm_seq_chk_i (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in),
  .sdo_out(sdo_out), .trigger_out(trigger_out), .start_in(start_in), .stop_in(stop_in));

// File: tfm_seq_top.sv
// Purpose: Time-of-flight sequence with calibration and serial register access.
// Assumes: All pins synchronous to clk_in; serial port is mode 0, MSB first.
// Notes:   Frame is one command byte (bit 6 write, bits 5..0 address),
//          then 8 write bits or 24 read bits.
`timescale 1ns/1ps
`include "tfm_params.svh"

// Behaviour
// - First calibration result is read-only: parity bit 23, value 22..0, zero at reset.
// - Second calibration result, read-only at 1Ch, same layout, zero at reset.
// - Start command makes a pulse on the trigger output to the front end.
// - Counting begins when a start pulse arrives from the front end.
// - Stop pulse halts the counter, then calibration runs before any result.
// - After calibration the captured count is published as the readable result.
// - Interval runs from start rising edge to stop rising edge.
module tfm_seq_top
  import tfm_pkg::*;
#(
  parameter int TRIG_CYCLES  = `TFM_TRIG_CYCLES,
  parameter int CAL2_PERIODS = `TFM_CAL2_PERIODS
)
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Serial host port
  input  wire logic sclk_in,
  input  wire logic cs_n_in,
  input  wire logic sdi_in,
  output logic      sdo_out,
  // Front end
  output logic      trigger_out,
  input  wire logic start_in,
  input  wire logic stop_in,
  // Calibration reference
  input  wire logic ref_clk_in
);

  localparam logic [22:0] CNT_MAX = 23'h7FFFFF;

  tfm_main_st_t st;
  tfm_main_st_t next_st;
  tfm_word_t    meas_word;
  tfm_word_t    first_cal_word;
  tfm_word_t    second_cal_word;
  logic         ld_meas;
  logic         ld_first;
  logic         ld_second;
  logic [22:0]  first_val;
  logic [22:0]  second_val;
  logic [23:0]  rd_data;
  logic         sclk_rise;
  logic         sclk_fall;
  logic         start_rise;
  logic         stop_rise;
  logic         ref_rise;
  logic         start_cmd;
  logic         busy;

  // ----------------------------------------
  // Edge detection on synchronous pins
  // ----------------------------------------
  assign sclk_rise  = !cs_n_in && sclk_in && !st.sclk_prev;
  assign sclk_fall  = !cs_n_in && !sclk_in && st.sclk_prev;
  assign start_rise = start_in && !st.start_prev;
  assign stop_rise  = stop_in && !st.stop_prev;
  assign ref_rise   = ref_clk_in && !st.ref_prev;
  assign busy       = (st.state != TFM_IDLE);

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_data = 24'h000000;
    unique case (st.addr)
      `TFM_ADDR_STATUS: begin
        rd_data[`TFM_STS_BUSY_BIT] = busy;
        rd_data[`TFM_STS_DONE_BIT] = st.done;
        rd_data[`TFM_STS_OVF_BIT]  = st.ovf;
      end
      `TFM_ADDR_MEAS_RESULT: rd_data = meas_word;
      `TFM_ADDR_FIRST_CAL:   rd_data = first_cal_word;
      `TFM_ADDR_SECOND_CAL:  rd_data = second_cal_word;
      default:               rd_data = 24'h000000;
    endcase
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_st            = st;
    next_st.sclk_prev  = sclk_in;
    next_st.start_prev = start_in;
    next_st.stop_prev  = stop_in;
    next_st.ref_prev   = ref_clk_in;
    ld_meas            = 1'b0;
    ld_first           = 1'b0;
    ld_second          = 1'b0;
    first_val          = st.cal_cnt;
    second_val         = st.cal_cnt;
    start_cmd          = 1'b0;

    // Serial frame: deselect restarts the bit count
    if (cs_n_in) begin
      next_st.bit_cnt = 5'h00;
    end else if (sclk_rise) begin
      next_st.rx = {st.rx[6:0], sdi_in};
      if (st.bit_cnt != 5'h1F) begin
        next_st.bit_cnt = st.bit_cnt + 5'h01;
      end
      if (st.bit_cnt == `TFM_CMD_BITS - 5'h01) begin
        next_st.addr = {st.rx[4:0], sdi_in};
        next_st.wr   = st.rx[`TFM_CMD_WRITE_BIT - 1];
      end
      if (st.wr && st.bit_cnt == `TFM_WR_LAST_BIT) begin
        // Start is self-clearing, so it is a strobe rather than a stored bit
        if (st.addr == `TFM_ADDR_CONFIG && sdi_in) begin
          start_cmd = 1'b1;
        end
        if (st.addr == `TFM_ADDR_STATUS && st.rx[`TFM_STS_DONE_BIT - 1]) begin
          next_st.done = 1'b0;
        end
      end
    end else if (sclk_fall) begin
      if (st.bit_cnt == `TFM_CMD_BITS && !st.wr) begin
        next_st.tx = rd_data;
      end else begin
        next_st.tx = {st.tx[22:0], 1'b0};
      end
    end

    // Measurement sequence
    unique case (st.state)
      TFM_IDLE: begin
        next_st.trigger = 1'b0;
        if (start_cmd) begin
          next_st.state    = TFM_TRIGGER;
          next_st.trigger  = 1'b1;
          next_st.trig_cnt = 8'h00;
          next_st.done     = 1'b0;
          next_st.ovf      = 1'b0;
        end
      end
      TFM_TRIGGER: begin
        next_st.trig_cnt = st.trig_cnt + 8'h01;
        if (st.trig_cnt == 8'(TRIG_CYCLES - 1)) begin
          next_st.trigger = 1'b0;
          next_st.state   = TFM_WAIT_START;
        end
      end
      TFM_WAIT_START: begin
        if (start_rise) begin
          next_st.meas_cnt = 23'h000001;
          next_st.state    = TFM_COUNT;
        end
      end
      TFM_COUNT: begin
        if (stop_rise) begin
          next_st.state = TFM_CAL_SYNC;
        end else if (st.meas_cnt == CNT_MAX) begin
          next_st.ovf = 1'b1;
        end else begin
          next_st.meas_cnt = st.meas_cnt + 23'h000001;
        end
      end
      TFM_CAL_SYNC: begin
        // Align calibration window to a reference edge
        if (ref_rise) begin
          next_st.cal_cnt = 23'h000000;
          next_st.state   = TFM_CAL_FIRST;
        end
      end
      TFM_CAL_FIRST: begin
        if (ref_rise) begin
          ld_first            = 1'b1;
          next_st.cal_cnt     = 23'h000000;
          next_st.ref_periods = 8'h01;
          next_st.state       = TFM_CAL_SECOND;
        end else if (st.cal_cnt != CNT_MAX) begin
          next_st.cal_cnt = st.cal_cnt + 23'h000001;
        end
      end
      TFM_CAL_SECOND: begin
        if (ref_rise && st.ref_periods == 8'(CAL2_PERIODS)) begin
          ld_second     = 1'b1;
          ld_meas       = 1'b1;
          next_st.done  = 1'b1;
          next_st.state = TFM_IDLE;
        end else begin
          if (ref_rise) begin
            next_st.ref_periods = st.ref_periods + 8'h01;
          end
          if (st.cal_cnt != CNT_MAX) begin
            next_st.cal_cnt = st.cal_cnt + 23'h000001;
          end
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st       <= '0;
      st.state <= TFM_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Result words with parity
  // ----------------------------------------
  tfm_par_reg u_meas (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .load_in  (ld_meas),
    .value_in (st.meas_cnt),
    .word_out (meas_word)
  );

  tfm_par_reg u_first_cal (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .load_in  (ld_first),
    .value_in (first_val),
    .word_out (first_cal_word)
  );

  tfm_par_reg u_second_cal (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .load_in  (ld_second),
    .value_in (second_val),
    .word_out (second_cal_word)
  );

  // Outputs straight from flops
  assign sdo_out     = st.tx[23];
  assign trigger_out = st.trigger;

endmodule : tfm_seq_top

// File: tfm_seq_top_tb_top.sv
// Purpose: Self-checking bench for the measurement sequencer.
// Assumes: Reference clock period of 8 clk, two second-cal periods.
// Notes:   Host frames are driven here; the front end is a model.
`timescale 1ns/1ps
`include "tfm_params.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH %0t got %h want %h", $time, (a), (b)); end end
module tfm_seq_top_tb_top
  import tfm_pkg::*;
;
  localparam int REF_PER = 8;
  logic       clk_in, rst_n_in, sclk, cs_n, sdi, sdo, trig, start, stop, ref_clk;
  logic [2:0] rc;
  logic [9:0] gap;
  int         fails, total_checks, trig_n;

  tfm_seq_top #(.CAL2_PERIODS(2)) tfm_seq_top_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .sclk_in(sclk), .cs_n_in(cs_n), .sdi_in(sdi), .sdo_out(sdo), .trigger_out(trig),
    .start_in(start), .stop_in(stop), .ref_clk_in(ref_clk));
  tfm_echo_model tfm_echo_model_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .trigger_in(trig),
    .gap_in(gap), .start_out(start), .stop_out(stop));

  // Clock, reference divider and trigger counter
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    rc      <= rc + 3'h1;
    ref_clk <= rc[2];
  end
  always @(posedge trig) trig_n++;

  function automatic logic [23:0] word(input logic [22:0] v);
    return {^v, v};
  endfunction : word

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // One frame; sclk phases of 3 clk keep above the 2 clk minimum
  task automatic xfer(input logic [7:0] cmd, input int n, input logic [23:0] wd,
                      output logic [23:0] rd);
    logic [31:0] sh;
    sh = {cmd, wd};
    rd = 24'h000000;
    @(posedge clk_in) cs_n <= 1'b0;
    for (int i = 0; i < 8 + n; i++) begin
      @(posedge clk_in) sdi <= sh[31 - i];
      repeat (2) @(posedge clk_in);
      sclk <= 1'b1;
      if (i >= 8) rd = {rd[22:0], sdo};
      repeat (3) @(posedge clk_in);
      sclk <= 1'b0;
    end
    repeat (3) @(posedge clk_in);
    cs_n <= 1'b1;
    @(posedge clk_in);
  endtask : xfer

  task automatic rd_reg(input logic [5:0] a, output logic [23:0] v);
    xfer({2'b00, a}, 24, 24'h000000, v);
  endtask : rd_reg

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    logic [23:0] v;
    xfer({2'b01, a}, 8, {d, 16'h0000}, v);
  endtask : wr_reg

  task automatic t_reset_values;
    logic [23:0] v;
    rd_reg(`TFM_ADDR_FIRST_CAL, v);
    `CHK(v, `TFM_RESULT_RESET)
    wr_reg(`TFM_ADDR_SECOND_CAL, 8'hFF);
    rd_reg(`TFM_ADDR_SECOND_CAL, v);
    `CHK(v, `TFM_RESULT_RESET)
    rd_reg(`TFM_ADDR_MEAS_RESULT, v);
    `CHK(v, `TFM_RESULT_RESET)
    $display("test reset_values done");
  endtask : t_reset_values

  task automatic t_measure(input logic [9:0] g);
    logic [23:0] v;
    int k, n0;
    gap <= g;
    n0 = trig_n;
    wr_reg(`TFM_ADDR_CONFIG, 8'h01);
    `CHK(trig_n, n0 + 1)
    k = 0;
    v = 24'h000000;
    while (v[1] !== 1'b1 && k < 20) begin
      rd_reg(`TFM_ADDR_STATUS, v);
      k++;
    end
    if (v[1] !== 1'b1) begin
      fails++;
      results;
    end
    `CHK(v[2:0], 3'b010)
    rd_reg(`TFM_ADDR_MEAS_RESULT, v);
    `CHK(v, word({13'h0000, g}))
    wr_reg(`TFM_ADDR_FIRST_CAL, 8'hA5);
    rd_reg(`TFM_ADDR_FIRST_CAL, v);
    `CHK(v, word(23'(REF_PER - 1)))
    rd_reg(`TFM_ADDR_SECOND_CAL, v);
    `CHK(v, word(23'(2 * REF_PER - 1)))
    wr_reg(`TFM_ADDR_STATUS, 8'h02);
    rd_reg(`TFM_ADDR_STATUS, v);
    `CHK(v[2:0], 3'b000)
    $display("test measure gap %0d done", g);
  endtask : t_measure

  // Reset after results are loaded must clear both calibration words
  task automatic t_mid_reset;
    logic [23:0] v;
    @(posedge clk_in) rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rd_reg(`TFM_ADDR_FIRST_CAL, v);
    `CHK(v, `TFM_RESULT_RESET)
    rd_reg(`TFM_ADDR_SECOND_CAL, v);
    `CHK(v, `TFM_RESULT_RESET)
    $display("test mid_reset done");
  endtask : t_mid_reset

  // Main sequence
  initial begin
    rst_n_in = 1'b0;
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    rc = 3'h0;
    ref_clk = 1'b0;
    gap = 10'd2;
    fails = 0;
    total_checks = 0;
    trig_n = 0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    t_reset_values;
    t_measure(10'd2);
    t_measure(10'd300);
    t_mid_reset;
    results;
  end
endmodule : tfm_seq_top_tb_top
